/* rtl/pcs_pkg.sv */
// package: register map, reset values and widths of the page-context stack
package pcs_pkg;
   localparam int          PAGE_W       = 8;
   localparam int          ADDR_W       = 8;
   localparam int          STACK_DEPTH  = 3;
   typedef logic [PAGE_W-1:0] pcs_page_t;
   typedef logic [ADDR_W-1:0] pcs_addr_t;
   // offsets follow the special-function map
   localparam pcs_addr_t   OFS_CURRENT  = 8'ha7;
   localparam pcs_addr_t   OFS_SECOND   = 8'h85;
   localparam pcs_addr_t   OFS_THIRD    = 8'h86;
   localparam pcs_page_t   PAGE_RESET   = 8'h00;
   localparam pcs_page_t   READ_UNMAPPED = 8'h00;
   typedef enum logic [1:0] {
      PCS_HOLD = 2'b00,
      PCS_PUSH = 2'b01,
      PCS_POP  = 2'b11
   } pcs_shift_t;
endpackage

/* rtl/pcs_core_if.sv */
// interface: stack shift requests and entry view between decoder and stack
`timescale 1ns/1ps
interface pcs_core_if;
   import pcs_pkg::*;
   pcs_shift_t shiftOp;
   logic [2:0] wrSel;
   pcs_page_t  wrData;
   pcs_page_t  entry0;
   pcs_page_t  entry1;
   pcs_page_t  entry2;
   modport ctrl  (output shiftOp, output wrSel, output wrData,
                  input entry0, input entry1, input entry2);
   modport stack (input shiftOp, input wrSel, input wrData,
                  output entry0, output entry1, output entry2);
endinterface

/* rtl/pcs_entry_stack.sv */
// three-entry page stack with shift and per-entry direct load
`timescale 1ns/1ps
module pcs_entry_stack
   import pcs_pkg::*;
(
   input wire logic   clk,
   input wire logic   sys_rst,
   pcs_core_if.stack  bus
);
   pcs_page_t entry_q [STACK_DEPTH];

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < STACK_DEPTH; i++)
            entry_q[i] <= PAGE_RESET;
      end
      else
      begin
         unique case (bus.shiftOp)
            PCS_PUSH:
            begin
               // deepest value falls off the end
               entry_q[2] <= entry_q[1];
               entry_q[1] <= entry_q[0];
            end
            PCS_POP:
            begin
               entry_q[0] <= entry_q[1];
               entry_q[1] <= entry_q[2];
            end
            default:
            begin
               // direct loads touch only the addressed entry
               for (int i = 0; i < STACK_DEPTH; i++)
                  if (bus.wrSel[i])
                     entry_q[i] <= bus.wrData;
            end
         endcase
      end
   end

   assign bus.entry0 = entry_q[0];
   assign bus.entry1 = entry_q[1];
   assign bus.entry2 = entry_q[2];
endmodule

/* rtl/pcs_page_stack.sv */
// top of the page-context stack: register port, core events, stack view
// Overview of operation
// - three byte entries: current, second, third
// - push on interrupt entry, pop on return
// - only interrupt events shift the stack
// - entry writes never push or pop
// - third-entry write loads all eight bits
// - return moves third entry into second
// - third-entry read returns value, no effects
`timescale 1ns/1ps
module pcs_page_stack
   import pcs_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire pcs_pkg::pcs_addr_t regAddr,
   input  wire pcs_pkg::pcs_page_t regWdata,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output logic [7:0]              regRdata,
   input  wire logic               intAccept,
   input  wire logic               intReturn,
   output logic [7:0]              currentPage
);
   import pcs_pkg::*;

   pcs_core_if link ();
   pcs_page_t  rdata_q;
   pcs_page_t  page_q;
   logic [2:0] addrHit;

   function automatic logic [2:0] decodeEntry(input pcs_addr_t a);
      decodeEntry = {a == OFS_THIRD, a == OFS_SECOND, a == OFS_CURRENT};
   endfunction

   // events own the cycle; a clashing write is dropped so a shift stays whole
   always_comb
   begin
      if (intAccept)
         link.shiftOp = PCS_PUSH;
      else if (intReturn)
         link.shiftOp = PCS_POP;
      else
         link.shiftOp = PCS_HOLD;
   end

   assign addrHit     = decodeEntry(regAddr);
   assign link.wrSel  = regWr ? addrHit : 3'h0;
   assign link.wrData = regWdata;

   pcs_entry_stack pcs_entry_stack_inst
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .bus     (link)
   );

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_q <= READ_UNMAPPED;
      else if (regRd)
      begin
         unique case (1'b1)
            addrHit[0]: rdata_q <= link.entry0;
            addrHit[1]: rdata_q <= link.entry1;
            addrHit[2]: rdata_q <= link.entry2;
            default:    rdata_q <= READ_UNMAPPED;
         endcase
      end
      else
         rdata_q <= READ_UNMAPPED;
   end

   // mirror of the top entry, kept in a flop so the output is registered
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         page_q <= PAGE_RESET;
      else if (intAccept)
         page_q <= link.entry0;
      else if (intReturn)
         page_q <= link.entry1;
      else if (regWr && addrHit[0])
         page_q <= regWdata;
      else
         page_q <= link.entry0;
   end

   assign regRdata    = rdata_q;
   assign currentPage = page_q;

   sequence s_thirdWrite;
      regWr && !intAccept && !intReturn && regAddr == OFS_THIRD;
   endsequence

   a_third_load: assert property (@(posedge clk) disable iff (sys_rst)
      s_thirdWrite |=> link.entry2 == $past(regWdata))
      else $error("third entry did not take written byte");
   a_pop_third: assert property (@(posedge clk) disable iff (sys_rst)
      intReturn && !intAccept |=> link.entry1 == $past(link.entry2))
      else $error("pop did not move third into second");
   a_push_shift: assert property (@(posedge clk) disable iff (sys_rst)
      intAccept |=> link.entry2 == $past(link.entry1) && link.entry1 == $past(link.entry0))
      else $error("push shift wrong");
   a_pop_top: assert property (@(posedge clk) disable iff (sys_rst)
      intReturn && !intAccept |=> link.entry0 == $past(link.entry1))
      else $error("pop did not restore top");
   a_no_shift: assert property (@(posedge clk) disable iff (sys_rst)
      !intAccept && !intReturn && !regWr |=> $stable(link.entry2) && $stable(link.entry1))
      else $error("stack moved without event");
   a_write_only: assert property (@(posedge clk) disable iff (sys_rst)
      s_thirdWrite |=> $stable(link.entry0) && $stable(link.entry1))
      else $error("entry write shifted stack");
   a_read_third: assert property (@(posedge clk) disable iff (sys_rst)
      regRd && regAddr == OFS_THIRD |=> regRdata == $past(link.entry2))
      else $error("third entry read wrong");
   a_read_clean: assert property (@(posedge clk) disable iff (sys_rst)
      regRd && !regWr && !intAccept && !intReturn |=> $stable(link.entry2))
      else $error("read disturbed stack");
   a_top_mirror: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 currentPage == link.entry0)
      else $error("current page output stale");

   // direct writes that reach the stack because no event owns the cycle
   sequence s_secondWrite;
      regWr && !intAccept && !intReturn && addrHit[1];
   endsequence

   sequence s_currentWrite;
      regWr && !intAccept && !intReturn && addrHit[0];
   endsequence

   sequence s_strayWrite;
      regWr && !intAccept && !intReturn && addrHit == 3'h0;
   endsequence

   // writes that collide with an event; the shift must take the cycle whole
   sequence s_pushClash;
      regWr && intAccept;
   endsequence

   sequence s_popClash;
      regWr && intReturn && !intAccept;
   endsequence

   sequence s_popOnly;
      intReturn && !intAccept;
   endsequence

   sequence s_idle;
      !intAccept && !intReturn && !regWr;
   endsequence

   sequence s_strayRead;
      regRd && addrHit == 3'h0;
   endsequence

   // direct writes land in the addressed entry only; unmapped writes land in none
   a_second_load: assert property (@(posedge clk) disable iff (sys_rst)
      s_secondWrite |=> link.entry1 == $past(regWdata))
      else $error("second entry did not take written byte");
   a_second_alone: assert property (@(posedge clk) disable iff (sys_rst)
      s_secondWrite |=> $stable(link.entry0) && $stable(link.entry2))
      else $error("second-entry write moved other entries");
   a_current_load: assert property (@(posedge clk) disable iff (sys_rst)
      s_currentWrite |=> link.entry0 == $past(regWdata) && currentPage == $past(regWdata))
      else $error("top entry did not take written byte");
   a_current_alone: assert property (@(posedge clk) disable iff (sys_rst)
      s_currentWrite |=> $stable(link.entry1) && $stable(link.entry2))
      else $error("top-entry write moved other entries");
   a_stray_write: assert property (@(posedge clk) disable iff (sys_rst)
      s_strayWrite |=> $stable(link.entry0) && $stable(link.entry1) && $stable(link.entry2))
      else $error("unmapped write changed the stack");

   // shift details the core relies on
   a_push_top: assert property (@(posedge clk) disable iff (sys_rst)
      intAccept |=> $stable(link.entry0))
      else $error("push changed the top entry");
   a_pop_deepest: assert property (@(posedge clk) disable iff (sys_rst)
      s_popOnly |=> $stable(link.entry2))
      else $error("pop changed the deepest entry");
   a_mirror_push: assert property (@(posedge clk) disable iff (sys_rst)
      intAccept |=> $stable(currentPage))
      else $error("current page moved on push");
   a_mirror_pop: assert property (@(posedge clk) disable iff (sys_rst)
      s_popOnly |=> currentPage == $past(link.entry1))
      else $error("current page not restored on pop");
   a_both_events: assert property (@(posedge clk) disable iff (sys_rst)
      intAccept && intReturn |=> link.entry1 == $past(link.entry0) && $stable(link.entry0))
      else $error("return won over entry");
   a_push_clash: assert property (@(posedge clk) disable iff (sys_rst)
      s_pushClash |=> link.entry2 == $past(link.entry1) && link.entry1 == $past(link.entry0)
         && $stable(link.entry0))
      else $error("write won over a push");
   a_pop_clash: assert property (@(posedge clk) disable iff (sys_rst)
      s_popClash |=> link.entry0 == $past(link.entry1) && link.entry1 == $past(link.entry2)
         && $stable(link.entry2))
      else $error("write won over a pop");
   a_quiet_top: assert property (@(posedge clk) disable iff (sys_rst)
      s_idle |=> $stable(link.entry0) && $stable(currentPage))
      else $error("top entry moved without event");

   // read port: data for one cycle, zero otherwise
   a_read_current: assert property (@(posedge clk) disable iff (sys_rst)
      regRd && addrHit[0] |=> regRdata == $past(link.entry0))
      else $error("top entry read wrong");
   a_read_second: assert property (@(posedge clk) disable iff (sys_rst)
      regRd && addrHit[1] |=> regRdata == $past(link.entry1))
      else $error("second entry read wrong");
   a_read_stray: assert property (@(posedge clk) disable iff (sys_rst)
      s_strayRead |=> regRdata == READ_UNMAPPED)
      else $error("unmapped read not zero");
   a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !regRd |=> regRdata == READ_UNMAPPED)
      else $error("read data held past its cycle");

   // left enabled in reset: state must read as cleared one edge after reset is seen
   a_reset_clear: assert property (@(posedge clk)
      sys_rst |=> link.entry0 == PAGE_RESET && link.entry1 == PAGE_RESET
         && link.entry2 == PAGE_RESET && currentPage == PAGE_RESET && regRdata == READ_UNMAPPED)
      else $error("stack not cleared by reset");
endmodule

/* bench/pcs_core_model.sv */
// core-side model: turns bench requests into interrupt events one clock later
`timescale 1ns/1ps
module pcs_core_model
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] evtReq,
   output logic            intAccept,
   output logic            intReturn
);
   // events leave on a clock edge so they never race the register strobes
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         intAccept <= 1'b0;
         intReturn <= 1'b0;
      end
      else
      begin
         intAccept <= evtReq[0];
         intReturn <= evtReq[1];
      end
   end
endmodule

/* bench/pcs_page_stack_test.sv */
// bench for the page-context stack: register access and interrupt shifts
`timescale 1ns/1ps
module pcs_page_stack_test;
   import pcs_pkg::*;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   pcs_addr_t  regAddr = 8'h00;
   pcs_page_t  regWdata = 8'h00;
   logic [7:0] regRdata;
   logic [7:0] currentPage;
   logic [1:0] evtReq = 2'h0;
   logic       intAccept;
   logic       intReturn;
   int         failCount = 0;
   int         checksDone = 0;

   pcs_page_stack pcs_page_stack_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .intAccept(intAccept), .intReturn(intReturn), .currentPage(currentPage));
   pcs_core_model pcs_core_model_inst (.clk(clk), .sys_rst(sys_rst), .evtReq(evtReq),
      .intAccept(intAccept), .intReturn(intReturn));

   initial
   begin
      forever #25 clk = ~clk;
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         failCount++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input pcs_addr_t a, input pcs_page_t d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input pcs_addr_t a, input pcs_page_t exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      cmp(regRdata, exp);
   endtask

   task automatic evt(input logic [1:0] code);
      @(posedge clk);
      evtReq <= code;
      @(posedge clk);
      evtReq <= 2'h0;
      @(posedge clk);
      #1;
   endtask

   task automatic t_reset;
      rd(OFS_CURRENT, 8'h00);
      rd(OFS_SECOND, 8'h00);
      rd(OFS_THIRD, 8'h00);
      rd(8'h00, READ_UNMAPPED);
   endtask

   task automatic t_third;
      wr(OFS_THIRD, 8'hff);
      rd(OFS_THIRD, 8'hff);
      wr(OFS_THIRD, 8'h81);
      rd(OFS_THIRD, 8'h81);
      rd(OFS_THIRD, 8'h81);
      rd(OFS_SECOND, 8'h00);
      cmp(currentPage, 8'h00);
   endtask

   task automatic t_push;
      wr(OFS_CURRENT, 8'h11);
      wr(OFS_SECOND, 8'h22);
      wr(OFS_THIRD, 8'h33);
      evt(2'h1);
      rd(OFS_CURRENT, 8'h11);
      rd(OFS_SECOND, 8'h11);
      rd(OFS_THIRD, 8'h22);
   endtask

   task automatic t_pop;
      wr(OFS_CURRENT, 8'h44);
      wr(OFS_THIRD, 8'h5a);
      #1;
      cmp(currentPage, 8'h44);
      evt(2'h2);
      cmp(currentPage, 8'h11);
      rd(OFS_SECOND, 8'h5a);
      rd(OFS_THIRD, 8'h5a);
   endtask

   // raise a core event and aim a write at the same edge; the shift must win
   task automatic clash(input logic [1:0] code, input pcs_addr_t a, input pcs_page_t d);
      @(posedge clk);
      evtReq <= code;
      @(posedge clk);
      evtReq <= 2'h0;
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask

   task automatic t_direct;
      wr(OFS_SECOND, 8'h3c);
      wr(OFS_CURRENT, 8'hc3);
      wr(8'h00, 8'hee);
      rd(OFS_CURRENT, 8'hc3);
      rd(OFS_SECOND, 8'h3c);
      rd(OFS_THIRD, 8'h5a);
      @(posedge clk);
      #1;
      cmp(regRdata, READ_UNMAPPED);
      cmp(currentPage, 8'hc3);
   endtask

   task automatic t_clash;
      clash(2'h1, OFS_THIRD, 8'h99);
      rd(OFS_THIRD, 8'h3c);
      rd(OFS_SECOND, 8'hc3);
      wr(OFS_CURRENT, 8'h12);
      clash(2'h2, OFS_SECOND, 8'h77);
      cmp(currentPage, 8'hc3);
      rd(OFS_SECOND, 8'h3c);
   endtask

   task automatic t_both;
      wr(OFS_THIRD, 8'h0f);
      evt(2'h3);
      rd(OFS_SECOND, 8'hc3);
      rd(OFS_THIRD, 8'h3c);
      cmp(currentPage, 8'hc3);
   endtask

   task automatic t_midreset;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_CURRENT, PAGE_RESET);
      rd(OFS_SECOND, PAGE_RESET);
      rd(OFS_THIRD, PAGE_RESET);
      cmp(currentPage, PAGE_RESET);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (2000) @(posedge clk);
      failCount++;
      tally_and_finish();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_third();
      t_push();
      t_pop();
      t_direct();
      t_clash();
      t_both();
      t_midreset();
      tally_and_finish();
   end
endmodule
